// [logic/tbl_fifo.sv]
// byte fifo with valid/ready on both sides and registered full/empty
// assumes both sides on clk; flags are honest from reset onward
`timescale 1ns/1ps
module tbl_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
        logic rdy;
    } tbl_fifo_st_t;
    tbl_fifo_st_t q, d;
    logic [W-1:0] mem [D];
    logic push, pop;
    assign push = in_valid && !q.full;
    assign pop = out_ready && !q.empty;
    always_comb begin
        d = q;
        if (push) begin
            d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        d.full = (d.cnt == (AW+1)'(D));
        d.empty = (d.cnt == '0);
        // ready kept in a flop so the port has no gate behind it
        d.rdy = !d.full;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.empty <= 1'b1;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
        if (push) begin
            mem[q.wp] <= in_data;
        end
    end
    assign in_ready = q.rdy;
    assign out_valid = !q.empty;
    assign out_data = mem[q.rp];
endmodule : tbl_fifo

// [logic/tbl_line_seq.sv]
// line encoder/decoder and protocol microsequencer of the token-bus core
// assumes config inputs come from core logic on clk; line_rx_in is a pin
`timescale 1ns/1ps
module tbl_line_seq #(
    parameter int RECON_CYCLES = 1000000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sys_clk_20,
    input wire logic driver_style_select,
    input wire logic diff_mode,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic line_tx_pulse_n,
    output logic line_tx_oe,
    output logic line_aux_clock_n,
    output logic line_drive_enable,
    input wire logic line_rx_in,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic token_seen,
    input wire logic own_reconfig_clear,
    output logic own_reconfig_flag,
    output logic [tbl_pkg::PC_W-1:0] seq_pc,
    output logic [7:0] seq_op,
    output logic [7:0] seq_imm
);
    import tbl_pkg::*;
    typedef struct packed {
        tbl_tx_st_t tst;
        logic [4:0] ui;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic bit1;
        logic pulse;
        logic px;
        logic poe;
        logic aux_n;
        logic den;
        tbl_rx_st_t rst;
        logic [4:0] rui;
        logic rseen;
        logic rprev;
        logic [3:0] rcnt;
        logic [7:0] rsh;
        logic rvalid;
        logic [7:0] rdata;
        logic [3:0] div;
        tbl_sq_st_t sst;
        logic [PC_W-1:0] pc;
        logic [7:0] op;
        logic [7:0] imm;
        logic [7:0] nop;
        logic [31:0] rtmr;
        logic recon;
    } tbl_st_t;
    tbl_st_t q, d;
    ////////////////////////////////////////////////////////////////////
    // rom contents
    function automatic logic [7:0] rom_init(input int i);
        case (i)
            0: rom_init = {OP_NOP, 6'h00};
            1: rom_init = NOP_LOOP;
            2: rom_init = OP_PLAIN;
            3: rom_init = 8'h00;
            default: rom_init = (i % 2 == 0) ? OP_JMP0 : 8'h00;
        endcase
    endfunction : rom_init
    logic [7:0] rom [ROM_WORDS];
    for (genvar gi = 0; gi < ROM_WORDS; gi++) begin : g_rom
        assign rom[gi] = rom_init(gi);
    end
    logic [7:0] rom_word;
    assign rom_word = (q.pc < PC_W'(ROM_WORDS)) ? rom[q.pc] : 8'h00;
    ////////////////////////////////////////////////////////////////////
    logic rx_s;
    tbl_sync u_rx_sync (
        .clk(clk),
        .reset(reset),
        .async_in(line_rx_in),
        .sync_out(rx_s)
    );
    logic f_valid, f_pop;
    logic [7:0] f_data;
    tbl_fifo #(.W(8), .D(8)) u_tx_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    ////////////////////////////////////////////////////////////////////
    // divider enables; in 20 MHz mode line bit timing and the sequencer run at half rate
    logic pc_en, ex_en, bit_en, ui_end, rui_end, fall, rbit, recon_hit;
    logic [3:0] pc_mask, ex_mask;
    assign pc_mask = sys_clk_20 ? PC_MASK_SLOW : PC_MASK_FAST;
    assign ex_mask = sys_clk_20 ? EX_MASK_SLOW : EX_MASK_FAST;
    assign pc_en = (q.div & pc_mask) == pc_mask;
    assign ex_en = (q.div & ex_mask) == ex_mask;
    assign bit_en = sys_clk_20 ? q.div[0] : 1'b1;
    assign ui_end = bit_en && (q.ui == UI_CYC - 5'h1);
    assign rui_end = bit_en && (q.rui == UI_CYC - 5'h1);
    assign fall = q.rprev && !rx_s;
    assign rbit = q.rseen || fall;
    assign recon_hit = (q.rtmr == 32'(RECON_CYCLES - 1)) && !token_seen;
    assign f_pop = ui_end && (q.tst == TX_SPACE);
    always_comb begin
        d = q;
        d.div = q.div + 4'h1;
        d.rvalid = 1'b0;
        ////////////////////////////////////////////////////////////////
        // transmit framing
        if (q.tst == TX_IDLE) begin
            // alert burst first
            // start on a bit tick, else a half-rate first interval is short
            if (f_valid && bit_en) begin
                d.tst = TX_ALERT;
                d.ui = '0;
                d.cnt = '0;
                d.bit1 = 1'b1;
            end
        end else if (bit_en) begin
            d.ui = ui_end ? 5'h0 : q.ui + 5'h1;
        end
        if (ui_end) begin
            case (q.tst)
                TX_ALERT: begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == ALERT_UIS - 4'h1) begin
                        d.tst = TX_MARK;
                        d.cnt = '0;
                    end
                end
                TX_MARK: begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == MARK_UIS - 4'h1) begin
                        d.tst = TX_SPACE;
                        d.bit1 = 1'b0;
                    end
                end
                TX_SPACE: begin
                    d.tst = TX_DATA;
                    d.cnt = '0;
                    d.bit1 = f_data[0];
                    d.sh = {1'b0, f_data[7:1]};
                end
                TX_DATA: begin
                    d.cnt = q.cnt + 4'h1;
                    d.bit1 = q.sh[0];
                    d.sh = {1'b0, q.sh[7:1]};
                    if (q.cnt == DATA_BITS - 4'h1) begin
                        d.cnt = '0;
                        d.bit1 = f_valid;
                        d.tst = f_valid ? TX_MARK : TX_IDLE;
                    end
                end
                default: d.tst = TX_IDLE;
            endcase
        end
        d.pulse = (d.tst != TX_IDLE) && d.bit1 && (d.ui < PULSE_CYC);
        d.den = diff_mode && (d.tst != TX_IDLE);
        // aux clock low in second half
        d.aux_n = !(!diff_mode && (d.tst != TX_IDLE) && (d.ui >= PULSE_CYC));
        d.px = driver_style_select ? !d.pulse : 1'b0;
        d.poe = driver_style_select ? 1'b1 : d.pulse;
        ////////////////////////////////////////////////////////////////
        // receive decoding, window centred on the first edge
        d.rprev = rx_s;
        if (q.rst == RX_IDLE) begin
            if (fall) begin
                d.rst = RX_HUNT;
                d.rui = HALF_UI;
                d.rseen = 1'b1;
                d.rcnt = '0;
            end
        end else if (bit_en) begin
            d.rseen = q.rseen || fall;
            d.rui = q.rui + 5'h1;
            if (rui_end) begin
                d.rui = '0;
                d.rseen = 1'b0;
                case (q.rst)
                    RX_HUNT: begin
                        if (rbit) begin
                            d.rcnt = (q.rcnt == 4'hF) ? q.rcnt : q.rcnt + 4'h1;
                        end else if (q.rcnt >= MARK_UIS) begin
                            d.rst = RX_DATA;
                            d.rcnt = '0;
                        end else begin
                            d.rst = RX_IDLE;
                        end
                    end
                    RX_DATA: begin
                        d.rsh = {rbit, q.rsh[7:1]};
                        d.rcnt = q.rcnt + 4'h1;
                        if (q.rcnt == DATA_BITS - 4'h1) begin
                            d.rvalid = 1'b1;
                            d.rdata = {rbit, q.rsh[7:1]};
                            d.rst = RX_HUNT;
                            d.rcnt = '0;
                        end
                    end
                    default: d.rst = RX_IDLE;
                endcase
            end
        end
        ////////////////////////////////////////////////////////////////
        // microsequencer
        case (q.sst)
            SQ_FETCH_OP: begin
                if (pc_en) begin
                    d.op = rom_word;
                    d.pc = q.pc + 1'b1;
                    d.sst = SQ_FETCH_IMM;
                end
            end
            SQ_FETCH_IMM: begin
                if (pc_en) begin
                    d.imm = rom_word;
                    d.pc = q.pc + 1'b1;
                    d.sst = SQ_EXEC;
                end
            end
            SQ_EXEC: begin
                if (ex_en) begin
                    d.sst = SQ_FETCH_OP;
                    case (q.op[7:6])
                        OP_NOP: begin
                            d.nop = q.imm;
                            if (q.imm != 8'h00) begin
                                d.sst = SQ_NOP;
                            end
                        end
                        OP_JMP: d.pc = {q.op[1:0], q.imm};
                        default: d.pc = q.pc;
                    endcase
                end
            end
            SQ_NOP: begin
                if (ex_en) begin
                    d.nop = q.nop - 8'h01;
                    if (q.nop == 8'h01) begin
                        d.sst = SQ_FETCH_OP;
                    end
                end
            end
            default: d.sst = SQ_FETCH_OP;
        endcase
        d.rtmr = token_seen ? 32'h0 : q.rtmr + 32'h1;
        if (own_reconfig_clear) begin
            d.recon = 1'b0;
        end
        if (recon_hit) begin
            d.rtmr = '0;
            d.pc = '0;
            d.sst = SQ_FETCH_OP;
            d.recon = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // quiet line in reset
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.px <= 1'b1;
            q.aux_n <= 1'b1;
            q.rprev <= 1'b1;
        end else begin
            q <= d;
        end
    end
    assign line_tx_pulse_n = q.px;
    assign line_tx_oe = q.poe;
    assign line_aux_clock_n = q.aux_n;
    assign line_drive_enable = q.den;
    assign rx_valid = q.rvalid;
    assign rx_data = q.rdata;
    assign own_reconfig_flag = q.recon;
    assign seq_pc = q.pc;
    assign seq_op = q.op;
    assign seq_imm = q.imm;
    ////////////////////////////////////////////////////////////////////
    AST_PULSE_LEN: assert property (
        @(posedge clk) disable iff (reset)
        ($rose(q.pulse) && !sys_clk_20 && $past(!sys_clk_20))
        |=> q.pulse[*7] ##1 !q.pulse
    ) else $error("one pulse not 200 ns");
    AST_OPEN_DRAIN: assert property (
        @(posedge clk) disable iff (reset)
        !$past(driver_style_select) |-> (!line_tx_oe || !line_tx_pulse_n)
    ) else $error("open drain drove high");
    AST_IDLE_SPACE: assert property (
        @(posedge clk) disable iff (reset)
        (q.tst == TX_IDLE) |-> !q.pulse && !line_tx_oe ||
        $past(driver_style_select)
    ) else $error("pulse while idle");
    AST_DIFF_EN: assert property (
        @(posedge clk) disable iff (reset)
        (q.pulse && $past(diff_mode)) |-> line_drive_enable
    ) else $error("pulse without drive enable");
    AST_RESET_QUIET: assert property (
        @(posedge clk)
        reset |=> line_tx_pulse_n && !line_tx_oe && line_aux_clock_n &&
        !line_drive_enable
    ) else $error("line active after reset");
    AST_ALERT_LEN: assert property (
        @(posedge clk) disable iff (reset)
        (q.tst == TX_MARK && $past(q.tst) == TX_ALERT)
        |-> $past(q.cnt) == 4'h5
    ) else $error("alert burst not six");
    AST_BYTE_FRAME: assert property (
        @(posedge clk) disable iff (reset)
        ($past(q.tst) == TX_DATA && q.tst != TX_DATA)
        |-> $past(q.cnt) == 4'h7 && $past(ui_end)
    ) else $error("byte not eight data bits");
    AST_NOP_HOLD: assert property (
        @(posedge clk) disable iff (reset)
        (q.sst == SQ_NOP && !recon_hit) |=> $stable(q.pc)
    ) else $error("pc moved in no-op loop");
    AST_RECON: assert property (
        @(posedge clk) disable iff (reset)
        recon_hit |=> q.pc == '0 && own_reconfig_flag
    ) else $error("timeout did not clear pc");
    AST_PC_RATE: assert property (
        @(posedge clk) disable iff (reset)
        (pc_en && !sys_clk_20) ##1 !sys_clk_20[*4]
        |-> !$past(pc_en, 1) && !$past(pc_en, 2) && !$past(pc_en, 3) &&
        pc_en
    ) else $error("pc clock not 10 MHz");
    AST_EX_RATE: assert property (
        @(posedge clk) disable iff (reset)
        (ex_en && sys_clk_20) |=> (!ex_en || !sys_clk_20)[*8]
    ) else $error("exec clock too fast");
endmodule : tbl_line_seq

// [logic/tbl_pkg.sv]
// constants and state types of the token-bus line phy and sequencer
// assumes one 40 MHz core clock; pulse and interval counts derive from it
// Contract
// - driver style bit picks push/pull or open drain; open drain by default.
// - each one bit is a 200 ns low pulse on the transmit line; in 20 MHz mode the pulse is 400 ns.
// - a low pulse within a receive interval reads as one, none as zero.
// - differential mode drives data only while line drive enable is active.
// - in reset transmit, auxiliary clock and drive enable outputs stay inactive.
// - backplane mode puts a clock on the auxiliary pulse output.
// - at 40 MHz program counter clock is 10 MHz, execution 5 MHz.
// - at 20 MHz program counter clock is 5 MHz, execution 2.5 MHz.
// - microprogram from 544x8 rom into op and immediate registers, then decoded.
// - no-op starts timed loop; program counter held until loop ends.
// - jump loads program counter with target taken from the rom.
// - reconfiguration timeout clears program counter and sets own reconfig flag.
// - every byte takes 11 intervals: two mark, one space, eight data.
// - every transmission opens with six mark intervals.
// - idle line stays spacing, no pulses driven.
package tbl_pkg;
    localparam int CLK_NS = 25;
    localparam int UI_NS = 400;
    localparam int PULSE_NS = 200;
    localparam logic [4:0] UI_CYC = 5'(UI_NS / CLK_NS);
    localparam logic [4:0] PULSE_CYC = 5'(PULSE_NS / CLK_NS);
    localparam logic [4:0] HALF_UI = 5'(UI_NS / CLK_NS / 2);
    localparam logic [3:0] ALERT_UIS = 4'h6;
    localparam logic [3:0] MARK_UIS = 4'h2;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam int ROM_WORDS = 544;
    localparam int PC_W = 10;
    localparam int SYS_FAST_MHZ = 40;
    localparam int PC_FAST_MHZ = 10;
    localparam int EX_FAST_MHZ = 5;
    // divider masks: all ones in the low bits marks one enable pulse
    localparam logic [3:0] PC_MASK_FAST = 4'(SYS_FAST_MHZ / PC_FAST_MHZ - 1);
    localparam logic [3:0] EX_MASK_FAST = 4'(SYS_FAST_MHZ / EX_FAST_MHZ - 1);
    localparam logic [3:0] PC_MASK_SLOW = 4'(2 * PC_MASK_FAST + 1);
    localparam logic [3:0] EX_MASK_SLOW = 4'(2 * EX_MASK_FAST + 1);
    localparam logic [1:0] OP_NOP = 2'h0;
    localparam logic [1:0] OP_JMP = 2'h1;
    localparam logic [7:0] OP_PLAIN = 8'h80;
    localparam logic [7:0] OP_JMP0 = 8'h40;
    localparam logic [7:0] NOP_LOOP = 8'h03;
    typedef enum logic [2:0] {
        TX_IDLE, TX_ALERT, TX_MARK, TX_SPACE, TX_DATA
    } tbl_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA} tbl_rx_st_t;
    typedef enum logic [1:0] {
        SQ_FETCH_OP, SQ_FETCH_IMM, SQ_EXEC, SQ_NOP
    } tbl_sq_st_t;
endpackage : tbl_pkg

// [logic/tbl_sync.sv]
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk
`timescale 1ns/1ps
module tbl_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } tbl_sync_st_t;
    tbl_sync_st_t q, d;
    always_comb begin
        d.s1 = async_in;
        d.s2 = q.s1;
    end
    // idle line level is high, so reset to high
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end
    assign sync_out = q.s2;
endmodule : tbl_sync

// [test/tbl_line_partner.sv]
// far node on the line: resolves the transmit wire, sends framed bytes
// assumes a pull-up on the shared line and a 400 ns unit interval
`timescale 1ns/1ps
module tbl_line_partner (
    input wire logic line_tx_pulse_n,
    input wire logic line_tx_oe,
    output logic tx_wire,
    output logic rx_wire
);
    ////////////////////////////////////////////////////////////////////////
    // pull-up holds released line
    assign tx_wire = line_tx_oe ? line_tx_pulse_n : 1'b1;
    initial rx_wire = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // one low pulse per one
    task automatic send_ui(input logic b);
        if (b) begin
            rx_wire = 1'b0;
            #200;
            rx_wire = 1'b1;
            #200;
        end else begin
            #400;
        end
    endtask : send_ui
    // gap lets the node answer late
    task automatic send_frame(input logic [7:0] b[$], input int gap_ns);
        #(gap_ns);
        repeat (6) send_ui(1'b1);
        foreach (b[i]) begin
            send_ui(1'b1);
            send_ui(1'b1);
            send_ui(1'b0);
            for (int k = 0; k < 8; k++) send_ui(b[i][k]);
        end
    endtask : send_frame
endmodule : tbl_line_partner

// [test/tbl_line_seq_tb.sv]
// self-checking bench of the line phy and microsequencer
// assumes the partner model on the line pins, 40 MHz clock
`timescale 1ns/1ps
module tbl_line_seq_tb;
    import tbl_pkg::*;
    logic clk, reset, sys_clk_20, driver_style_select, diff_mode;
    logic tx_valid, tx_ready, line_tx_pulse_n, line_tx_oe, line_aux_clock_n;
    logic line_drive_enable, rx_valid, token_seen, own_reconfig_clear;
    logic own_reconfig_flag, tx_wire, rx_wire, wire_q, aux_q;
    logic [7:0] tx_data, rx_data, seq_op, seq_imm;
    logic [PC_W-1:0] seq_pc;
    int n_fail, n_checks, cyc, pw, aux_cnt, n_acc, refuse_at, low_start;
    int falls[$];
    logic [7:0] rx_q[$];
    // short timeout keeps the reconfig run brief
    tbl_line_seq #(.RECON_CYCLES(200)) i_tbl_line_seq (.clk(clk),
        .reset(reset), .sys_clk_20(sys_clk_20),
        .driver_style_select(driver_style_select), .diff_mode(diff_mode),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .line_tx_pulse_n(line_tx_pulse_n), .line_tx_oe(line_tx_oe),
        .line_aux_clock_n(line_aux_clock_n),
        .line_drive_enable(line_drive_enable), .line_rx_in(rx_wire),
        .rx_valid(rx_valid), .rx_data(rx_data), .token_seen(token_seen),
        .own_reconfig_clear(own_reconfig_clear),
        .own_reconfig_flag(own_reconfig_flag), .seq_pc(seq_pc),
        .seq_op(seq_op), .seq_imm(seq_imm));
    tbl_line_partner i_tbl_line_partner (.line_tx_pulse_n(line_tx_pulse_n),
        .line_tx_oe(line_tx_oe), .tx_wire(tx_wire), .rx_wire(rx_wire));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // line monitor sampling the resolved wire
    always @(posedge clk) begin
        cyc++;
        if (wire_q && !tx_wire) begin
            falls.push_back(cyc);
            low_start = cyc;
        end
        if (!wire_q && tx_wire && !reset)
            check("pulse_width", cyc - low_start, pw);
        if (diff_mode && !tx_wire)
            check("drive_en", line_drive_enable, 1'b1);
        if (aux_q && !line_aux_clock_n) aux_cnt++;
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        wire_q = tx_wire;
        aux_q = line_aux_clock_n;
    end
    ////////////////////////////////////////////////////////////////////////
    // valid held until ready is seen at an edge
    task automatic push(input logic [7:0] d);
        int n;
        n = 0;
        tx_data = d;
        tx_valid = 1'b1;
        @(posedge clk);
        while (tx_ready !== 1'b1 && n < 4000) begin
            if (refuse_at < 0) refuse_at = n_acc;
            n++;
            @(posedge clk);
        end
        n_acc++;
        @(negedge clk);
    endtask : push
    task automatic tx_frame(input logic [7:0] b[$], input logic s20,
                            input logic ds, input logic dm);
        int ui, nones;
        logic exp[$];
        @(negedge clk);
        sys_clk_20 = s20;
        driver_style_select = ds;
        diff_mode = dm;
        ui = (s20 ? 2 : 1) * int'(UI_CYC);
        pw = (s20 ? 2 : 1) * int'(PULSE_CYC);
        repeat (4) @(negedge clk);
        check("oe_idle", line_tx_oe, ds);
        falls.delete();
        aux_cnt = 0;
        refuse_at = -1;
        n_acc = 0;
        repeat (6) exp.push_back(1'b1);
        foreach (b[i]) begin
            exp.push_back(1'b1);
            exp.push_back(1'b1);
            exp.push_back(1'b0);
            for (int k = 0; k < 8; k++) exp.push_back(b[i][k]);
        end
        foreach (b[i]) push(b[i]);
        tx_valid = 1'b0;
        repeat (exp.size() * ui + 40) @(negedge clk);
        nones = 0;
        foreach (exp[k]) begin
            nones += int'(exp[k]);
            check("tx_bit", falls.size() > 0 &&
                  (falls[0] + k * ui) inside {falls}, exp[k]);
        end
        check("pulse_count", falls.size(), nones);
        check("aux_count", aux_cnt, dm ? 0 : exp.size());
        check("drained", tx_ready, 1'b1);
    endtask : tx_frame
    task automatic t_fill();
        logic [7:0] q[$];
        for (int i = 0; i < 10; i++) q.push_back(8'(i * 37 + 1));
        tx_frame(q, 1'b0, 1'b1, 1'b1);
        check("fifo_refuse", refuse_at, 8);
    endtask : t_fill
    task automatic rst_check();
        @(negedge clk);
        check("rst_pulse", line_tx_pulse_n, 1'b1);
        check("rst_oe", line_tx_oe, 1'b0);
        check("rst_aux", line_aux_clock_n, 1'b1);
        check("rst_den", line_drive_enable, 1'b0);
        check("rst_flag", own_reconfig_flag, 1'b0);
        check("rst_pc", seq_pc, 0);
    endtask : rst_check
    task automatic t_reset_mid();
        @(negedge clk);
        diff_mode = 1'b1;
        driver_style_select = 1'b1;
        push(8'hFF);
        tx_valid = 1'b0;
        repeat (37) @(negedge clk);
        reset = 1'b1;
        repeat (3) rst_check();
        reset = 1'b0;
    endtask : t_reset_mid
    // async frame from the far node
    task automatic t_rx();
        rx_q.delete();
        #7;
        i_tbl_line_partner.send_frame('{8'h5A, 8'hC3}, 300);
        repeat (100) @(negedge clk);
        check("rx_count", rx_q.size(), 2);
        check("rx_byte0", rx_q[0], 8'h5A);
        check("rx_byte1", rx_q[1], 8'hC3);
    endtask : t_rx
    task automatic t_seq(input logic s20);
        int t, last, gap, maxg, step, zeros;
        logic [PC_W-1:0] prev;
        @(negedge clk);
        sys_clk_20 = s20;
        token_seen = 1'b1;
        own_reconfig_clear = 1'b1;
        step = s20 ? 8 : 4;
        @(negedge clk);
        own_reconfig_clear = 1'b0;
        repeat (20) @(posedge clk);
        prev = seq_pc;
        last = -1;
        maxg = 0;
        zeros = 0;
        for (t = 0; t < 600; t++) begin
            @(posedge clk);
            if (seq_pc !== prev) begin
                gap = t - last;
                if (last >= 0) check("pc_step", gap % step, 0);
                if (last >= 0 && gap > maxg) maxg = gap;
                if (seq_pc === '0) begin
                    zeros++;
                    check("jump_op", seq_op, OP_JMP0);
                    check("jump_imm", seq_imm, 8'h00);
                end
                last = t;
                prev = seq_pc;
            end
        end
        check("nop_hold", maxg >= 6 * step, 1'b1);
        check("jump_back", zeros > 0, 1'b1);
        check("no_recon", own_reconfig_flag, 1'b0);
    endtask : t_seq
    task automatic t_recon();
        int n;
        @(negedge clk);
        token_seen = 1'b0;
        n = 0;
        while (own_reconfig_flag !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("recon_time", n inside {[195:205]}, 1'b1);
        check("recon_pc", seq_pc, 0);
        token_seen = 1'b1;
        own_reconfig_clear = 1'b1;
        @(negedge clk);
        own_reconfig_clear = 1'b0;
        @(negedge clk);
        check("recon_clear", own_reconfig_flag, 1'b0);
    endtask : t_recon
    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        n_checks = 0;
        cyc = 0;
        pw = 8;
        wire_q = 1'b1;
        aux_q = 1'b1;
        reset = 1'b1;
        {sys_clk_20, driver_style_select, diff_mode, tx_valid} = 4'h0;
        {token_seen, own_reconfig_clear} = 2'h0;
        tx_data = 8'h00;
        repeat (12) @(posedge clk);
        rst_check();
        reset = 1'b0;
        tx_frame('{8'hA5}, 1'b0, 1'b0, 1'b0);
        tx_frame('{8'h81}, 1'b1, 1'b1, 1'b0);
        t_fill();
        t_reset_mid();
        t_rx();
        t_seq(1'b0);
        t_seq(1'b1);
        t_recon();
        final_report();
    end
    // limit well above the longest expected run
    initial begin
        #500000;
        n_fail++;
        final_report();
    end
endmodule : tbl_line_seq_tb
